//--- hw/afwrr_ctrl.sv
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
// Contract
// - data held stable around write strobe rise
// - write only 10 ns after full rises
// - read only 10 ns after empty rises
// - clear device after power-up, before writes
// - strobes high 45 ns before, 15 after clear
// - read strobe high around rewind release
// - no rewind in chained depth expansion
module afwrr_ctrl (
	input wire logic clk,
	input wire logic rst,
	input wire logic [afwrr_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [afwrr_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic write_n,
	output logic read_n,
	output logic pointer_clear_n,
	output logic rewind_n,
	output logic chain_in_n,
	output logic [afwrr_pkg::DATA_W-1:0] write_data,
	input wire logic [afwrr_pkg::DATA_W-1:0] read_data,
	input wire logic store_full_n,
	input wire logic store_empty_n
);
	localparam int SW = afwrr_pkg::DATA_W + 2;

	afwrr_pkg::afwrr_state_e state;
	logic [afwrr_pkg::CNT_W-1:0] cnt;
	logic [afwrr_pkg::ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [SW-1:0] pins_s;
	logic full_s_n;
	logic empty_s_n;
	logic [afwrr_pkg::DATA_W-1:0] read_data_s;
	logic [afwrr_pkg::DATA_W-1:0] rd_word;
	logic [afwrr_pkg::ST_W-1:0] sticky;
	logic [afwrr_pkg::ST_W-1:0] sticky_set;
	logic [afwrr_pkg::ST_W-1:0] sticky_clr;
	logic do_write;
	logic idle;
	logic cnt_done;
	logic req_clear;
	logic req_rewind;
	logic req_read;
	logic req_write;
	logic go_clear;
	logic go_rewind;
	logic go_read;
	logic go_write;
	logic rd_capture;

	function automatic logic reg_mapped(input logic [afwrr_pkg::ADDR_W-1:0] a);
		return (a == afwrr_pkg::REG_CMD) || (a == afwrr_pkg::REG_WDATA) ||
			(a == afwrr_pkg::REG_RDATA) || (a == afwrr_pkg::REG_STATUS);
	endfunction

	function automatic logic [afwrr_pkg::CNT_W-1:0] load(input int n);
		return afwrr_pkg::CNT_W'(n - 1);
	endfunction

	// ----------------------------------------------------------------
	// pin input synchronisers
	// ----------------------------------------------------------------
	afwrr_sync #(
		.WIDTH(SW)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.d({store_full_n, store_empty_n, read_data}),
		.q(pins_s)
	);
	assign full_s_n = pins_s[SW-1];
	assign empty_s_n = pins_s[SW-2];
	assign read_data_s = pins_s[afwrr_pkg::DATA_W-1:0];

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			// ready from reset: both readies low means both halves taken
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= afwrr_pkg::RESP_OKAY;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= reg_mapped(aw_addr) ? afwrr_pkg::RESP_OKAY :
					afwrr_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	assign idle = (state == afwrr_pkg::AFWRR_IDLE);
	assign req_clear = do_write && w_strb[0] && (aw_addr == afwrr_pkg::REG_CMD) &&
		w_data[afwrr_pkg::CMD_CLEAR_BIT];
	assign req_rewind = do_write && w_strb[0] && (aw_addr == afwrr_pkg::REG_CMD) &&
		w_data[afwrr_pkg::CMD_REWIND_BIT] && !w_data[afwrr_pkg::CMD_CLEAR_BIT];
	assign req_read = do_write && w_strb[0] && (aw_addr == afwrr_pkg::REG_CMD) &&
		w_data[afwrr_pkg::CMD_READ_BIT] && !w_data[afwrr_pkg::CMD_CLEAR_BIT] &&
		!w_data[afwrr_pkg::CMD_REWIND_BIT];
	assign req_write = do_write && w_strb[0] && (aw_addr == afwrr_pkg::REG_WDATA);
	assign go_clear = req_clear && idle;
	assign go_rewind = req_rewind && idle;
	assign go_read = req_read && idle && empty_s_n;
	assign go_write = req_write && idle && full_s_n;
	assign cnt_done = (cnt == '0);
	assign rd_capture = (state == afwrr_pkg::AFWRR_RD_LOW) && cnt_done;

	// ----------------------------------------------------------------
	// status flags, set wins over clear
	// ----------------------------------------------------------------
	always_comb begin
		sticky_set = '0;
		sticky_set[afwrr_pkg::ST_WR_REFUSED] = req_write && idle && !full_s_n;
		sticky_set[afwrr_pkg::ST_RD_REFUSED] = req_read && idle && !empty_s_n;
		sticky_set[afwrr_pkg::ST_CMD_DROPPED] = (req_write || req_read || req_clear ||
			req_rewind) && !idle;
		sticky_set[afwrr_pkg::ST_RD_VALID] = rd_capture;
		sticky_clr = '0;
		if (do_write && w_strb[0] && (aw_addr == afwrr_pkg::REG_STATUS)) begin
			sticky_clr = w_data[afwrr_pkg::ST_W-1:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sticky <= '0;
		end else begin
			sticky <= (sticky & ~sticky_clr) | sticky_set;
		end
	end

	// ----------------------------------------------------------------
	// pin sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			// host reset starts with a device clear
			state <= afwrr_pkg::AFWRR_CLR_LOW;
			cnt <= load(afwrr_pkg::CLR_LOW_CYC);
			write_n <= 1'b1;
			read_n <= 1'b1;
			pointer_clear_n <= 1'b0;
			rewind_n <= 1'b1;
			chain_in_n <= 1'b0;
			write_data <= '0;
			rd_word <= '0;
		end else begin
			chain_in_n <= 1'b0;
			if (!cnt_done) begin
				cnt <= cnt - 1'b1;
			end
			case (state)
			afwrr_pkg::AFWRR_IDLE: begin
				if (go_clear) begin
					state <= afwrr_pkg::AFWRR_CLR_LOW;
					cnt <= load(afwrr_pkg::CLR_LOW_CYC);
					pointer_clear_n <= 1'b0;
				end else if (go_rewind) begin
					state <= afwrr_pkg::AFWRR_RW_LOW;
					cnt <= load(afwrr_pkg::RW_LOW_CYC);
					rewind_n <= 1'b0;
				end else if (go_read) begin
					state <= afwrr_pkg::AFWRR_RD_LOW;
					cnt <= load(afwrr_pkg::RD_LOW_CYC);
					read_n <= 1'b0;
				end else if (go_write) begin
					state <= afwrr_pkg::AFWRR_WR_SETUP;
					cnt <= load(afwrr_pkg::WR_SETUP_CYC);
					write_data <= w_data[afwrr_pkg::DATA_W-1:0];
				end
			end
			afwrr_pkg::AFWRR_WR_SETUP: begin
				if (cnt_done) begin
					state <= afwrr_pkg::AFWRR_WR_LOW;
					cnt <= load(afwrr_pkg::WR_LOW_CYC);
					write_n <= 1'b0;
				end
			end
			afwrr_pkg::AFWRR_WR_LOW: begin
				if (cnt_done) begin
					state <= afwrr_pkg::AFWRR_WR_HOLD;
					cnt <= load(afwrr_pkg::WR_HOLD_CYC);
					write_n <= 1'b1;
				end
			end
			afwrr_pkg::AFWRR_WR_HOLD: begin
				if (cnt_done) begin
					state <= afwrr_pkg::AFWRR_SETTLE;
					cnt <= load(afwrr_pkg::SETTLE_CYC);
				end
			end
			afwrr_pkg::AFWRR_RD_LOW: begin
				if (cnt_done) begin
					// sample before the strobe rises
					rd_word <= read_data_s;
					read_n <= 1'b1;
					state <= afwrr_pkg::AFWRR_RECOVER;
					cnt <= load(afwrr_pkg::RD_REC_CYC);
				end
			end
			afwrr_pkg::AFWRR_CLR_LOW: begin
				if (cnt_done) begin
					pointer_clear_n <= 1'b1;
					state <= afwrr_pkg::AFWRR_RECOVER;
					cnt <= load(afwrr_pkg::CLR_REC_CYC);
				end
			end
			afwrr_pkg::AFWRR_RW_LOW: begin
				if (cnt_done) begin
					rewind_n <= 1'b1;
					state <= afwrr_pkg::AFWRR_RECOVER;
					cnt <= load(afwrr_pkg::RW_REC_CYC);
				end
			end
			afwrr_pkg::AFWRR_RECOVER: begin
				if (cnt_done) begin
					state <= afwrr_pkg::AFWRR_SETTLE;
					cnt <= load(afwrr_pkg::SETTLE_CYC);
				end
			end
			afwrr_pkg::AFWRR_SETTLE: begin
				// flags settle and pass the synchroniser before the next access
				if (cnt_done) begin
					state <= afwrr_pkg::AFWRR_IDLE;
				end
			end
			default: begin
				state <= afwrr_pkg::AFWRR_IDLE;
				cnt <= '0;
				write_n <= 1'b1;
				read_n <= 1'b1;
				pointer_clear_n <= 1'b1;
				rewind_n <= 1'b1;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= afwrr_pkg::RESP_OKAY;
		end else begin
			if (!s_axi_arready && !s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= reg_mapped(s_axi_araddr) ? afwrr_pkg::RESP_OKAY :
					afwrr_pkg::RESP_SLVERR;
				s_axi_rdata <= '0;
				case (s_axi_araddr)
				afwrr_pkg::REG_WDATA: begin
					s_axi_rdata <= {{(32 - afwrr_pkg::DATA_W){1'b0}}, write_data};
				end
				afwrr_pkg::REG_RDATA: begin
					s_axi_rdata <= {{(32 - afwrr_pkg::DATA_W){1'b0}}, rd_word};
				end
				afwrr_pkg::REG_STATUS: begin
					s_axi_rdata <= {{(32 - afwrr_pkg::ST_W){1'b0}}, sticky[afwrr_pkg::ST_W-1:3],
						!empty_s_n, !full_s_n, !idle};
				end
				default: begin
					s_axi_rdata <= '0;
				end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule // afwrr_ctrl

//--- include/afwrr_pkg.sv
package afwrr_pkg;

	// ----------------------------------------------------------------
	// clock and pin timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int DATA_W = 9;
	localparam int STORE_DEPTH = 512;
	localparam int SYNC_DEPTH = 2;

	localparam int T_WPW_NS = 65;
	localparam int T_WR_NS = 15;
	localparam int T_DS_NS = 20;
	localparam int T_DH_NS = 10;
	localparam int T_WFF_NS = 60;
	localparam int T_FFW_NS = 10;
	localparam int T_RPW_NS = 65;
	localparam int T_A_NS = 65;
	localparam int T_RR_NS = 15;
	localparam int T_RFF_NS = 60;
	localparam int T_EFR_NS = 10;
	localparam int T_RS_NS = 65;
	localparam int T_RSS_NS = 45;
	localparam int T_RSR_NS = 15;
	localparam int T_RSC_NS = 80;
	localparam int T_RT_NS = 65;
	localparam int T_RTR_NS = 15;
	localparam int T_RTC_NS = 80;

	function automatic int cyc_min(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int cyc_max(input int ns);
		int c;
		c = ns / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int max2(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	localparam int WR_SETUP_CYC = cyc_min(T_DS_NS);
	localparam int WR_LOW_CYC = cyc_min(T_WPW_NS);
	localparam int WR_HOLD_CYC = max2(cyc_min(T_DH_NS), cyc_min(T_WR_NS));
	localparam int RD_LOW_CYC = max2(cyc_min(T_RPW_NS), cyc_min(T_A_NS)) + SYNC_DEPTH;
	localparam int RD_REC_CYC = cyc_min(T_RR_NS);
	localparam int CLR_LOW_CYC = max2(cyc_min(T_RS_NS), cyc_min(T_RSS_NS));
	localparam int CLR_REC_CYC = cyc_min(T_RSR_NS);
	localparam int RW_LOW_CYC = cyc_min(T_RT_NS);
	localparam int RW_REC_CYC = cyc_min(T_RTR_NS);
	localparam int FLAG_CYC = max2(max2(cyc_max(T_WFF_NS), cyc_max(T_RFF_NS)),
		max2(cyc_min(T_RSC_NS), cyc_min(T_RTC_NS)));
	localparam int SETTLE_CYC = FLAG_CYC + max2(cyc_min(T_FFW_NS), cyc_min(T_EFR_NS))
		+ SYNC_DEPTH;
	localparam int CNT_W = 4;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] REG_CMD = 4'h0;
	localparam logic [ADDR_W-1:0] REG_WDATA = 4'h4;
	localparam logic [ADDR_W-1:0] REG_RDATA = 4'h8;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'hc;

	localparam int CMD_CLEAR_BIT = 0;
	localparam int CMD_REWIND_BIT = 1;
	localparam int CMD_READ_BIT = 2;

	localparam int ST_BUSY = 0;
	localparam int ST_FULL = 1;
	localparam int ST_EMPTY = 2;
	localparam int ST_WR_REFUSED = 3;
	localparam int ST_RD_REFUSED = 4;
	localparam int ST_CMD_DROPPED = 5;
	localparam int ST_RD_VALID = 6;
	localparam int ST_W = 7;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		AFWRR_IDLE = 4'h0,
		AFWRR_WR_SETUP = 4'h1,
		AFWRR_WR_LOW = 4'h3,
		AFWRR_WR_HOLD = 4'h2,
		AFWRR_SETTLE = 4'h6,
		AFWRR_RD_LOW = 4'h7,
		AFWRR_RECOVER = 4'h5,
		AFWRR_CLR_LOW = 4'h4,
		AFWRR_RW_LOW = 4'hc
	} afwrr_state_e;

endpackage

//--- hw/afwrr_sync.sv
`timescale 1ns/10ps
module afwrr_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] stage1;

	// first stage feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1 <= '1;
			q <= '1;
		end else begin
			stage1 <= d;
			q <= stage1;
		end
	end
endmodule // afwrr_sync

//--- verif/afwrr_ctrl_asserts.sv
`timescale 1ns/10ps
module afwrr_ctrl_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic write_n,
	input wire logic read_n,
	input wire logic pointer_clear_n,
	input wire logic rewind_n,
	input wire logic chain_in_n,
	input wire logic [afwrr_pkg::DATA_W-1:0] write_data,
	input wire logic store_full_n,
	input wire logic store_empty_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ----
	// pin sequencing
	// ----
	clr_power_a: assert property ($fell(rst) |->
		!pointer_clear_n[*2] ##[1:3] pointer_clear_n)
		else $error("no device clear after reset");
	clr_quiet_a: assert property (!pointer_clear_n |-> write_n && read_n)
		else $error("strobe active during clear");
	clr_recover_a: assert property ($rose(pointer_clear_n) |->
		(write_n && read_n)[*2])
		else $error("strobe too soon after clear");
	wr_pulse_a: assert property ($fell(write_n) |-> !write_n[*2] ##1 write_n)
		else $error("write pulse width wrong");
	wr_data_a: assert property (!write_n || !$past(write_n) |-> $stable(write_data))
		else $error("write data moved around strobe");
	wr_full_a: assert property (!store_full_n[*8] |-> write_n)
		else $error("write strobe while full");
	rd_pulse_a: assert property ($fell(read_n) |-> !read_n[*4] ##1 read_n)
		else $error("read pulse width wrong");
	rd_empty_a: assert property (!store_empty_n[*8] |-> read_n)
		else $error("read strobe while empty");
	rw_guard_a: assert property ($fell(rewind_n) |->
		(read_n && !rewind_n)[*2] ##1 (read_n && rewind_n)[*2])
		else $error("rewind pulse or guard wrong");
	chain_off_a: assert property (chain_in_n == 1'b0)
		else $error("chain input not grounded");
	wr_c: cover property ($fell(write_n));
	rd_c: cover property ($fell(read_n));
	rw_c: cover property ($fell(rewind_n));
endmodule // afwrr_ctrl_chk

bind afwrr_ctrl afwrr_ctrl_chk chk_u (.clk(clk), .rst(rst), .write_n(write_n), .read_n(read_n),
	.pointer_clear_n(pointer_clear_n), .rewind_n(rewind_n), .chain_in_n(chain_in_n),
	.write_data(write_data), .store_full_n(store_full_n), .store_empty_n(store_empty_n));

//--- verif/afwrr_fifo_model.sv
`timescale 1ns/10ps
module afwrr_fifo_model (
	input wire logic write_n,
	input wire logic read_n,
	input wire logic pointer_clear_n,
	input wire logic rewind_n,
	input wire logic [8:0] write_data,
	output logic [8:0] read_data,
	output logic store_full_n,
	output logic store_empty_n
);
	logic [8:0] mem [0:511];
	logic [8:0] wp = 9'h000;
	logic [8:0] rp = 9'h000;
	logic [8:0] rq = 9'h0aa;
	int cnt = 0;
	logic wr_ok = 1'b0;
	logic rd_ok = 1'b0;
	// ----
	// flags from pointer distance
	// ----
	assign #10 store_full_n = !(cnt == 512 || (wr_ok && cnt == 511));
	// last read pulls empty low from its start
	assign #10 store_empty_n = !(cnt == 0 || (rd_ok && cnt == 1));
	assign read_data = rq;
	always @(negedge write_n) wr_ok = store_full_n && pointer_clear_n;
	always @(posedge write_n) if (wr_ok) begin
		mem[wp] = write_data;
		wp = wp + 9'h001;
		cnt = cnt + 1;
		wr_ok = 1'b0;
	end
	always @(negedge read_n) begin
		rd_ok = store_empty_n;
		if (rd_ok) rq <= #20 mem[rp];
	end
	always @(posedge read_n) if (rd_ok) begin
		rp = rp + 9'h001;
		cnt = cnt - 1;
		rd_ok = 1'b0;
		rq <= #5 ~rq; // released bus
	end
	always @(pointer_clear_n or rewind_n) begin
		if (!pointer_clear_n) begin
			wp = 9'h000;
			rp = 9'h000;
			cnt = 0;
		end else if (!rewind_n) begin
			rp = 9'h000;
			cnt = int'(wp);
		end
	end
endmodule // afwrr_fifo_model

//--- verif/afwrr_ctrl_tb.sv
`timescale 1ns/10ps
module afwrr_ctrl_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic write_n, read_n, pointer_clear_n, rewind_n, store_full_n, store_empty_n;
	logic [8:0] write_data, read_data;
	int n_fail = 0, checks = 0, cyc = 0;
	initial forever #25 clk = ~clk;
	afwrr_ctrl dut_u (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.write_n(write_n), .read_n(read_n), .pointer_clear_n(pointer_clear_n),
		.rewind_n(rewind_n), .chain_in_n(), .write_data(write_data), .read_data(read_data),
		.store_full_n(store_full_n), .store_empty_n(store_empty_n));
	afwrr_fifo_model dev_u (.write_n(write_n), .read_n(read_n),
		.pointer_clear_n(pointer_clear_n), .rewind_n(rewind_n), .write_data(write_data),
		.read_data(read_data), .store_full_n(store_full_n), .store_empty_n(store_empty_n));
	// ----
	// shared tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge clk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic op(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] s;
		logic [1:0] r;
		wr(a, d, r);
		do rd(afwrr_pkg::REG_STATUS, s, r); while (s[afwrr_pkg::ST_BUSY] !== 1'b0);
	endtask
	task automatic get(input logic [31:0] e);
		logic [31:0] v;
		logic [1:0] r;
		op(afwrr_pkg::REG_CMD, 32'h0000_0004);
		rd(afwrr_pkg::REG_RDATA, v, r);
		chk(v, e);
	endtask
	task automatic stat(input logic [3:0] e);
		logic [31:0] s;
		logic [1:0] r;
		rd(afwrr_pkg::REG_STATUS, s, r);
		chk({28'h000_0000, s[4:1]}, {28'h000_0000, e});
		wr(afwrr_pkg::REG_STATUS, 32'h0000_0078, r);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_rewind;
		stat(4'h2);
		op(afwrr_pkg::REG_WDATA, 32'h0000_01a5);
		op(afwrr_pkg::REG_WDATA, 32'h0000_005a);
		get(32'h0000_01a5);
		op(afwrr_pkg::REG_CMD, 32'h0000_0002);
		get(32'h0000_01a5);
		get(32'h0000_005a);
		stat(4'h2);
		op(afwrr_pkg::REG_CMD, 32'h0000_0004);
		stat(4'ha);
	endtask
	task automatic t_clear;
		op(afwrr_pkg::REG_WDATA, 32'h0000_00ff);
		stat(4'h0);
		op(afwrr_pkg::REG_CMD, 32'h0000_0001);
		stat(4'h2);
	endtask
	task automatic t_bus;
		logic [31:0] v;
		logic [1:0] r;
		wr(4'h6, 32'h0000_0001, r);
		chk({30'h0000_0000, r}, {30'h0000_0000, afwrr_pkg::RESP_SLVERR});
		rd(4'h6, v, r);
		chk({30'h0000_0000, r}, {30'h0000_0000, afwrr_pkg::RESP_SLVERR});
		chk(v, 32'h0000_0000);
	endtask
	task automatic t_full;
		for (int i = 0; i < 512; i++) op(afwrr_pkg::REG_WDATA, 32'(i));
		stat(4'h1);
		op(afwrr_pkg::REG_WDATA, 32'h0000_01ff);
		stat(4'h5);
		get(32'h0000_0000);
		stat(4'h0);
		op(afwrr_pkg::REG_WDATA, 32'h0000_0055);
		stat(4'h1);
		for (int i = 1; i < 512; i++) get(32'(i));
		get(32'h0000_0055);
		stat(4'h2);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			n_fail++;
			results;
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		op(afwrr_pkg::REG_STATUS, 32'h0000_0078);
		t_rewind;
		t_clear;
		t_bus;
		t_full;
		results;
	end
endmodule // afwrr_ctrl_tb
